// *** hw/iocs_top.v ***
// card select decode, control gating and busy/done flags
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "iocs_consts.vh"
module iocs_top #(
    parameter CODE_W = `IOCS_CODE_W,
    parameter CTRL_W = `IOCS_CTRL_W
) (
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire [`IOCS_ADDR_W-1:0]  paddr,
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [`IOCS_APB_W-1:0]   pwdata,
    output reg  [`IOCS_APB_W-1:0]   prdata,
    output reg                      pready,
    output reg                      pslverr,
    input  wire [CODE_W-1:0]        device_select_lines,
    input  wire                     bus_start,
    input  wire                     bus_clear,
    input  wire                     bus_io_reset,
    input  wire [CTRL_W-1:0]        bus_ctrl,
    input  wire                     interrupt_acknowledge,
    input  wire                     request_enable_strobe,
    input  wire                     prio_in,
    input  wire                     status_select,
    input  wire                     ctrl_select,
    input  wire                     periph_set_busy,
    input  wire                     periph_set_done,
    input  wire                     periph_done_clk,
    input  wire                     done_clk_en,
    output reg                      primary_code_match,
    output reg                      secondary_code_match,
    output reg  [CTRL_W-1:0]        periph_ctrl,
    output reg                      select_done_line,
    output reg                      select_busy_line,
    output reg  [`IOCS_DATA_W-1:0]  ack_data,
    output reg                      ack_data_oe_n,
    output reg                      interrupt_request_line,
    output reg                      irq
);
    reg  [`IOCS_CODE_HI_W-1:0] code_sw_r;
    reg                        int_mask_r;
    reg                        busy_r;
    reg                        done_r;
    reg                        req_r;
    reg                        strobe_d_r;
    reg                        dclk_d_r;
    reg  [`IOCS_EV_W-1:0]      istat_r;
    reg  [`IOCS_EV_W-1:0]      ien_r;
    reg                        busy_d_r;
    reg                        done_d_r;
    reg                        req_d_r;
    wire [3:0]                 per_s;
    wire                       s_set_busy;
    wire                       s_set_done;
    wire                       s_dclk;
    wire                       s_dclk_en;
    wire                       code_hit;
    wire                       pm;
    wire                       sm;
    wire                       start_ev;
    wire                       done_ev;
    wire                       clr_ev;
    wire                       wr;
    wire                       rd;
    wire [`IOCS_EV_W-1:0]      ev;
    wire [`IOCS_EV_W-1:0]      iclr;

    // peripheral inputs are asynchronous
    // synchronise peripheral inputs
    iocs_sync #(
        .W (4)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({done_clk_en, periph_done_clk, periph_set_done, periph_set_busy}),
        .q       (per_s)
    );
    assign s_set_busy = per_s[0];
    assign s_set_done = per_s[1];
    assign s_dclk     = per_s[2];
    assign s_dclk_en  = per_s[3];

    assign code_hit = (device_select_lines[CODE_W-1:1] == code_sw_r);
    assign pm = code_hit & ~device_select_lines[0];
    assign sm = code_hit & device_select_lines[0];

    assign start_ev = (bus_start & pm) | s_set_busy;
    // direct set or clock edge while busy
    assign done_ev  = s_set_done | (s_dclk & ~dclk_d_r & s_dclk_en & busy_r);
    assign clr_ev   = (bus_clear & pm) | bus_io_reset;

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_r     <= 1'b0;
            done_r     <= 1'b0;
            dclk_d_r   <= 1'b0;
            strobe_d_r <= 1'b0;
            req_r      <= 1'b0;
        end
        else
        begin
            dclk_d_r   <= s_dclk;
            strobe_d_r <= request_enable_strobe;
            if (clr_ev)
            begin
                busy_r <= 1'b0;
                done_r <= 1'b0;
            end
            else if (done_ev)
            begin
                done_r <= 1'b1;
                busy_r <= 1'b0;
            end
            else if (start_ev)
            begin
                busy_r <= 1'b1;
                done_r <= 1'b0;
            end
            if (clr_ev || !done_r)
                req_r <= 1'b0;
            else if (request_enable_strobe && !strobe_d_r && !int_mask_r)
                req_r <= 1'b1;
        end
    end

    // registered outputs toward bus and peripheral
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            primary_code_match     <= 1'b0;
            secondary_code_match   <= 1'b0;
            periph_ctrl            <= {CTRL_W{1'b0}};
            select_done_line       <= 1'b0;
            select_busy_line       <= 1'b0;
            ack_data               <= {`IOCS_DATA_W{1'b0}};
            ack_data_oe_n          <= 1'b1;
            interrupt_request_line <= 1'b0;
        end
        else
        begin
            primary_code_match     <= pm;
            secondary_code_match   <= sm;
            periph_ctrl            <= (pm | ctrl_select) ? bus_ctrl : {CTRL_W{1'b0}};
            select_done_line       <= (pm | status_select) & done_r;
            select_busy_line       <= (pm | status_select) & busy_r;
            ack_data               <= {code_sw_r, 1'b0, {(`IOCS_DATA_W-CODE_W){1'b0}}};
            ack_data_oe_n          <= ~(interrupt_acknowledge & req_r & prio_in);
            interrupt_request_line <= req_r;
        end
    end

    // events: rising done, rising busy, rising request
    assign ev   = {req_r & ~req_d_r, busy_r & ~busy_d_r, done_r & ~done_d_r};
    assign iclr = (wr && pready && paddr == `IOCS_ADDR_ICLR) ? pwdata[`IOCS_EV_W-1:0]
                                                   : {`IOCS_EV_W{1'b0}};

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            code_sw_r  <= `IOCS_CODE_RST;
            int_mask_r <= 1'b0;
            ien_r      <= {`IOCS_EV_W{1'b0}};
            istat_r    <= {`IOCS_EV_W{1'b0}};
            busy_d_r   <= 1'b0;
            done_d_r   <= 1'b0;
            req_d_r    <= 1'b0;
            irq        <= 1'b0;
            prdata     <= {`IOCS_APB_W{1'b0}};
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end
        else
        begin
            busy_d_r <= busy_r;
            done_d_r <= done_r;
            req_d_r  <= req_r;
            // set wins over clear
            istat_r  <= (istat_r & ~iclr) | ev;
            irq      <= |(istat_r & ien_r);
            pready   <= psel & ~penable;
            pslverr  <= 1'b0;
            if (psel && !penable)
            begin
                case (paddr)
                    `IOCS_ADDR_CODE,
                    `IOCS_ADDR_CTRL,
                    `IOCS_ADDR_FLAGS,
                    `IOCS_ADDR_ISTAT,
                    `IOCS_ADDR_IEN,
                    `IOCS_ADDR_ICLR: pslverr <= 1'b0;
                    default:         pslverr <= 1'b1;
                endcase
                case (paddr)
                    `IOCS_ADDR_CODE:  prdata <= {{(`IOCS_APB_W-`IOCS_CODE_HI_W){1'b0}}, code_sw_r};
                    `IOCS_ADDR_CTRL:  prdata <= {{(`IOCS_APB_W-1){1'b0}}, int_mask_r};
                    `IOCS_ADDR_FLAGS: prdata <= {{(`IOCS_APB_W-3){1'b0}}, req_r, busy_r, done_r};
                    `IOCS_ADDR_ISTAT: prdata <= {{(`IOCS_APB_W-`IOCS_EV_W){1'b0}}, istat_r};
                    `IOCS_ADDR_IEN:   prdata <= {{(`IOCS_APB_W-`IOCS_EV_W){1'b0}}, ien_r};
                    default:          prdata <= {`IOCS_APB_W{1'b0}};
                endcase
            end
            if (wr && pready)
            begin
                case (paddr)
                    `IOCS_ADDR_CODE: code_sw_r  <= pwdata[`IOCS_CODE_HI_W-1:0];
                    `IOCS_ADDR_CTRL: int_mask_r <= pwdata[0];
                    `IOCS_ADDR_IEN:  ien_r      <= pwdata[`IOCS_EV_W-1:0];
                    default:         int_mask_r <= int_mask_r;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** include/iocs_consts.vh ***
// constants for the card select and busy/done flag block
// Overview of operation
// - compare six-bit select code every operation
// - even code primary match, odd code secondary
// - selected card drives done and busy lines
// - acknowledge winner returns code on data 10-15
// - control pulses pass only while primary selected or strapped
// - start or set-busy sets busy, clears done
// - done setting clears busy
// - done set directly or by clock while busy
// - clock enable low ignores done clocks
// - start or set-busy clears done
// - clear pulse or io reset clears both
// - flags tested on primary match or whenever strapped
// - done unmasked plus request strobe raises request
`ifndef IOCS_CONSTS_VH
`define IOCS_CONSTS_VH
`define IOCS_CODE_W      6
`define IOCS_CODE_HI_W   5
`define IOCS_CTRL_W      4
`define IOCS_DATA_W      16
`define IOCS_CODE_LSB    16
`define IOCS_SYNC_W      3
`define IOCS_APB_W       32
`define IOCS_ADDR_W      12
`define IOCS_ADDR_CODE   12'h000
`define IOCS_ADDR_CTRL   12'h004
`define IOCS_ADDR_FLAGS  12'h008
`define IOCS_ADDR_ISTAT  12'h00c
`define IOCS_ADDR_IEN    12'h010
`define IOCS_ADDR_ICLR   12'h014
`define IOCS_CODE_RST    5'h00
`define IOCS_EV_W        3
`define IOCS_EV_DONE     0
`define IOCS_EV_BUSY     1
`define IOCS_EV_REQ      2
`endif

// *** hw/iocs_sync.v ***
// three-stage synchroniser with change qualified on agreement
`timescale 1ns/1ps
`default_nettype none
module iocs_sync #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    genvar i;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // output follows once stages two and three agree
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    q[i] <= 1'b0;
                else if (s2_r[i] == s3_r[i])
                    q[i] <= s3_r[i];
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** tb/iocs_monitor.sv ***
// assertion checker for card select and flag outputs
`timescale 1ns/1ps
`default_nettype none
module iocs_monitor #(
    parameter CODE_W = 6,
    parameter CTRL_W = 4
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [CODE_W-1:0] device_select_lines,
    input wire logic              bus_io_reset,
    input wire logic              interrupt_acknowledge,
    input wire logic              request_enable_strobe,
    input wire logic              status_select,
    input wire logic              ctrl_select,
    input wire logic              primary_code_match,
    input wire logic              secondary_code_match,
    input wire logic [CTRL_W-1:0] periph_ctrl,
    input wire logic              select_done_line,
    input wire logic              select_busy_line,
    input wire logic [15:0]       ack_data,
    input wire logic              ack_data_oe_n,
    input wire logic              interrupt_request_line
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    even_primary_a: assert property (primary_code_match |-> !$past(device_select_lines[0]))
        else $error("primary match on odd code");
    odd_secondary_a: assert property (secondary_code_match |-> $past(device_select_lines[0]))
        else $error("secondary match on even code");
    flag_excl_a: assert property (!(select_busy_line && select_done_line))
        else $error("busy and done both shown");
    sel_gate_a: assert property ((select_busy_line || select_done_line) |->
        (primary_code_match || $past(primary_code_match) || $past(status_select)))
        else $error("status lines driven while unselected");
    ctrl_gate_a: assert property ((|periph_ctrl) |->
        (primary_code_match || $past(primary_code_match) || $past(ctrl_select)))
        else $error("control passed while unselected");
    ack_drive_a: assert property (!ack_data_oe_n |->
        ($past(interrupt_acknowledge) && !ack_data[10])) else $error("code driven badly");
    io_reset_a: assert property (bus_io_reset [*2] |=>
        (!select_busy_line && !select_done_line)) else $error("flags survive io reset");
    req_strobe_a: assert property ($rose(interrupt_request_line) |->
        ($past(request_enable_strobe) || $past(request_enable_strobe, 2)))
        else $error("request raised without strobe");
    apb_ready_a: assert property ((pready || pslverr) |-> (pready && $past(psel && !penable)))
        else $error("answer outside access phase");
endmodule
`default_nettype wire

// *** tb/iocs_bus_model.sv ***
// bus controller model issuing programmed i/o to the card
`timescale 1ns/1ps
`default_nettype none
module iocs_bus_model (
    input  wire logic       pclk,
    output var logic  [5:0] device_select_lines,
    output var logic  [3:0] bus_ctrl,
    output var logic        interrupt_acknowledge,
    output wire logic       bus_start,
    output wire logic       bus_clear,
    output wire logic       bus_io_reset,
    output wire logic       request_enable_strobe
);
    logic [3:0] p = 4'h0;
    assign {request_enable_strobe, bus_io_reset, bus_clear, bus_start} = p;
    initial {device_select_lines, bus_ctrl, interrupt_acknowledge} = 11'h000;
    task automatic drive(input logic [5:0] c, input logic [3:0] k, input logic a);
        @(posedge pclk);
        device_select_lines <= c;
        bus_ctrl <= k;
        interrupt_acknowledge <= a;
    endtask
    // pulse of n cycles: 0 start, 1 clear, 2 io reset, 3 request strobe
    task automatic pulse(input int k, input int n);
        @(posedge pclk);
        p <= 4'h1 << k;
        repeat (n) @(posedge pclk);
        p <= 4'h0;
    endtask
endmodule
`default_nettype wire

// *** tb/io_card_select_and_flags_test.sv ***
// self-checking bench for card select and flag block
`timescale 1ns/1ps
`default_nettype none
`include "iocs_consts.vh"
module io_card_select_and_flags_test;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, r;
    logic        prio_in = 0, status_select = 0, ctrl_select = 0, done_clk_en = 1;
    logic [2:0]  pin = 3'h0;
    wire  [31:0] prdata;
    wire  [5:0]  device_select_lines;
    wire  [3:0]  bus_ctrl, periph_ctrl;
    wire  [15:0] ack_data;
    wire         pready, pslverr, bus_start, bus_clear, bus_io_reset, interrupt_acknowledge;
    wire         request_enable_strobe, primary_code_match, secondary_code_match;
    wire         select_done_line, select_busy_line, ack_data_oe_n, interrupt_request_line, irq;
    wire         periph_set_busy = pin[0], periph_set_done = pin[1], periph_done_clk = pin[2];
    int          fails = 0, compares = 0;
    logic [12:0] rows [5] = '{{6'h12, 3'b010, 4'ha}, {6'h13, 3'b001, 4'h0},
        {6'h14, 3'b000, 4'h0}, {6'h32, 3'b000, 4'h0}, {6'h15, 3'b100, 4'ha}};
    logic [16:0] irqs [4] = '{{`IOCS_ADDR_IEN, 4'h1, 1'b1}, {`IOCS_ADDR_IEN, 4'h0, 1'b0},
        {`IOCS_ADDR_IEN, 4'h1, 1'b1}, {`IOCS_ADDR_ICLR, 4'h7, 1'b0}};
    iocs_top u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .device_select_lines, .bus_start, .bus_clear, .bus_io_reset,
        .bus_ctrl, .interrupt_acknowledge, .request_enable_strobe, .prio_in, .status_select,
        .ctrl_select, .periph_set_busy, .periph_set_done, .periph_done_clk, .done_clk_en,
        .primary_code_match, .secondary_code_match, .periph_ctrl, .select_done_line,
        .select_busy_line, .ack_data, .ack_data_oe_n, .interrupt_request_line, .irq);
    iocs_bus_model u_bus (.pclk, .device_select_lines, .bus_ctrl, .interrupt_acknowledge,
        .bus_start, .bus_clear, .bus_io_reset, .request_enable_strobe);
    initial forever #2 pclk = ~pclk;
    task automatic conclude;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk) n++; while (pready !== 1'b1 && n < 16);
        chk(pready, 1);
        if (pready !== 1'b1) conclude;
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic pp(input int k);
        pin[k] <= 1;
        cyc(6);
        pin[k] <= 0;
    endtask
    task automatic flags(input logic [1:0] x);
        cyc(8);
        chk({select_busy_line, select_done_line}, x);
    endtask
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk({ack_data_oe_n, interrupt_request_line, irq}, 3'b100);
        apb(1, `IOCS_ADDR_CODE, 32'h9);
        apb(0, `IOCS_ADDR_CODE, 32'h0);
        chk({e, r}, {1'b0, 32'h9});
        apb(0, 12'h0fc, 32'h0);
        chk({e, r}, {1'b1, 32'h0});
        // peripheral side answers primary, secondary or neither; strap passes control
        foreach (rows[i])
        begin
            ctrl_select <= rows[i][6];
            u_bus.drive(rows[i][12:7], 4'ha, 0);
            cyc(3);
            chk({primary_code_match, secondary_code_match, periph_ctrl}, rows[i][5:0]);
        end
        ctrl_select <= 0;
        status_select <= 1;
        u_bus.drive(6'h12, 4'h0, 0);
        u_bus.pulse(0, 1);
        flags(2'b10);
        pp(1);
        flags(2'b01);
        pp(0);
        flags(2'b10);
        done_clk_en <= 0;
        cyc(6);
        pp(2);
        flags(2'b10);
        done_clk_en <= 1;
        cyc(6);
        pp(2);
        flags(2'b01);
        u_bus.pulse(3, 1);
        cyc(3);
        chk(interrupt_request_line, 1);
        apb(0, `IOCS_ADDR_FLAGS, 32'h0);
        chk(r, 32'h5);
        prio_in <= 1;
        u_bus.drive(6'h12, 4'h0, 1);
        cyc(3);
        chk({ack_data_oe_n, ack_data[15:10]}, {1'b0, 6'h12});
        u_bus.drive(6'h12, 4'h0, 0);
        foreach (irqs[i])
        begin
            apb(1, irqs[i][16:5], {28'h0, irqs[i][4:1]});
            cyc(2);
            chk(irq, irqs[i][0]);
        end
        apb(0, `IOCS_ADDR_ISTAT, 32'h0);
        chk(r, 32'h0);
        u_bus.pulse(0, 1);
        flags(2'b10);
        chk(interrupt_request_line, 0);
        status_select <= 0;
        u_bus.drive(6'h14, 4'h0, 0);
        flags(2'b00);
        u_bus.drive(6'h12, 4'h0, 0);
        flags(2'b10);
        u_bus.pulse(1, 1);
        flags(2'b00);
        u_bus.pulse(0, 1);
        u_bus.drive(6'h14, 4'h0, 0);
        status_select <= 1;
        flags(2'b10);
        u_bus.pulse(2, 2);
        flags(2'b00);
        conclude;
    end
endmodule
bind iocs_top iocs_monitor #(.CODE_W(CODE_W), .CTRL_W(CTRL_W)) u_mon (.pclk, .presetn, .psel,
    .penable, .pready, .pslverr, .device_select_lines, .bus_io_reset, .interrupt_acknowledge,
    .request_enable_strobe, .status_select, .ctrl_select, .primary_code_match,
    .secondary_code_match, .periph_ctrl, .select_done_line, .select_busy_line, .ack_data,
    .ack_data_oe_n, .interrupt_request_line);
`default_nettype wire
